// file: core/xcd_pkg.sv
package xcd_pkg;
  // register bus shape
  localparam int          XCD_AW       = 10;     // byte address width
  localparam int          XCD_DW       = 32;     // data width
  localparam int          XCD_IDX_LSB  = 2;      // byte addr = index * 4
  // register indices
  localparam logic [7:0]  XCD_IDX_PER  = 8'h4f;  // peripheral decode enable
  localparam logic [7:0]  XCD_IDX_ROM  = 8'h54;  // rom segment attributes
  localparam logic [7:0]  XCD_IDX_MCTL = 8'h20;  // memory select control
  localparam logic [7:0]  XCD_IDX_STAT = 8'h21;  // decode status, read only
  // reset values
  localparam logic [7:0]  XCD_RST_PER  = 8'h4f;
  localparam logic [7:0]  XCD_RST_ROM  = 8'h00;
  localparam logic [7:0]  XCD_RST_MCTL = 8'h00;
  // field positions
  localparam int          XCD_B_CFG    = 7;      // config ram decode enable
  localparam int          XCD_B_P92    = 6;      // port 92 enable
  localparam int          XCD_F_LPT    = 4;      // lsb of parallel field
  localparam int          XCD_F_CMB    = 2;      // lsb of serial b field
  localparam int          XCD_F_CMA    = 0;      // lsb of serial a field
  localparam int          XCD_B_MEN    = 4;      // master memory select enable
  // field codes
  localparam logic [1:0]  XCD_COM1     = 2'h0;
  localparam logic [1:0]  XCD_COM2     = 2'h1;
  localparam logic [1:0]  XCD_LPT1     = 2'h0;
  localparam logic [1:0]  XCD_LPT2     = 2'h1;
  localparam logic [1:0]  XCD_LPT3     = 2'h2;
  // encoded select codes, all ones is idle
  localparam logic [2:0]  XCD_E_IDLE   = 3'h7;
  localparam logic [2:0]  XCD_E_CPAGE  = 3'h0;
  localparam logic [2:0]  XCD_E_CMEM   = 3'h1;
  localparam logic [2:0]  XCD_E_P92    = 3'h2;
  localparam logic [2:0]  XCD_E_COMA   = 3'h3;
  localparam logic [2:0]  XCD_E_COMB   = 3'h4;
  localparam logic [2:0]  XCD_E_LPT    = 3'h5;
  // i/o addresses
  localparam logic [15:0] XCD_A_CPAGE  = 16'h0c00;
  localparam logic [7:0]  XCD_A_CMEM   = 8'h08;   // bits 15:8
  localparam logic [15:0] XCD_A_P92    = 16'h0092;
  localparam logic [12:0] XCD_A_COM1   = 13'h007f; // bits 15:3
  localparam logic [12:0] XCD_A_COM2   = 13'h005f;
  localparam logic [13:0] XCD_A_LPT1   = 14'h00ef; // bits 15:2
  localparam logic [12:0] XCD_A_LPT2   = 13'h006f; // bits 15:3
  localparam logic [12:0] XCD_A_LPT3   = 13'h004f;
  // rom window, bits 23:16, four 16 KB segments
  localparam logic [7:0]  XCD_A_ROM    = 8'h0c;
  localparam logic [1:0]  XCD_A_ROMQ   = 2'h0;    // bits 17:16 of the address
  localparam int          XCD_SEGS     = 4;
endpackage

// file: core/xcd_decode.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
module xcd_decode
  import xcd_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                nrst_i,      // bus reset, active low
  // avalon-mm slave
  input  wire logic [XCD_AW-1:0]   address_i,
  input  wire logic                read_i,
  input  wire logic                write_i,
  input  wire logic [XCD_DW-1:0]   writedata_i,
  input  wire logic [3:0]          byteenable_i,
  output logic      [XCD_DW-1:0]   readdata_o,
  output logic                     waitrequest_o,
  // bus cycle to decode, same clock
  input  wire logic                cyc_valid_i,
  input  wire logic                cyc_io_i,    // 1 i/o, 0 memory
  input  wire logic                cyc_write_i,
  input  wire logic [23:0]         cyc_addr_i,
  // decode results
  output logic [2:0]               encoded_select_lines_o,
  output logic                     xbus_transceiver_enable_n_o,
  output logic                     system_memory_select_n_o
);

  //////////////////////////////////////////////////////////////////////////
  // register file state
  logic [7:0]        periph_ctl;     // decode enables
  logic [7:0]        rom_attr;       // segment read/write enables
  logic [7:0]        mem_ctl;        // master memory select control
  logic              ack_q;          // second cycle of an access
  logic [XCD_DW-1:0] rdata;          // read data register
  logic [7:0]        next_periph_ctl;
  logic [7:0]        next_rom_attr;
  logic [7:0]        next_mem_ctl;
  logic              next_ack_q;
  logic [XCD_DW-1:0] next_rdata;
  logic [7:0]        reg_idx;        // word index of the access
  logic              wr_take;        // write lands this edge
  logic [7:0]        wbyte;          // low byte lane of write data

  //////////////////////////////////////////////////////////////////////////
  // decode state
  logic [2:0]        enc;            // registered encoded select
  logic              xcvr_n;         // registered transceiver enable
  logic              memsel_n;       // registered memory select
  logic [2:0]        next_enc;
  logic              next_xcvr_n;
  logic              next_memsel_n;

  // field views
  logic [1:0]        sel_a;
  logic [1:0]        sel_b;
  logic [1:0]        sel_lpt;
  logic [15:0]       io_a;
  logic [1:0]        seg;
  logic [XCD_SEGS-1:0] seg_rd;
  logic [XCD_SEGS-1:0] seg_wr;

  assign sel_a   = periph_ctl[XCD_F_CMA +: 2];
  assign sel_b   = periph_ctl[XCD_F_CMB +: 2];
  assign sel_lpt = periph_ctl[XCD_F_LPT +: 2];
  assign io_a    = cyc_addr_i[15:0];
  assign seg     = cyc_addr_i[15:14];

  // lower bit of each pair reads, upper bit writes
  for (genvar g = 0; g < XCD_SEGS; g++) begin : g_seg
    assign seg_rd[g] = rom_attr[2*g];
    assign seg_wr[g] = rom_attr[2*g + 1];
  end

  // serial range match, reserved and disabled codes never match
  function automatic logic com_hit(input logic [1:0]  sel,
                                   input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    if (sel == XCD_COM1) begin
      hit = (a[15:3] == XCD_A_COM1);
    end else if (sel == XCD_COM2) begin
      hit = (a[15:3] == XCD_A_COM2);
    end
    return hit;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on the second edge
  assign reg_idx       = address_i[XCD_AW-1:XCD_IDX_LSB];
  assign waitrequest_o = (read_i | write_i) & ~ack_q;
  assign wr_take       = write_i & ack_q & byteenable_i[0];
  assign wbyte         = writedata_i[7:0];
  assign readdata_o    = rdata;

  // next register values
  always_comb begin
    next_periph_ctl = periph_ctl;
    next_rom_attr   = rom_attr;
    next_mem_ctl    = mem_ctl;
    next_ack_q      = (read_i | write_i) & ~ack_q;
    next_rdata      = rdata;
    if (wr_take) begin
      // only the low lane carries the 8-bit registers
      unique case (reg_idx)
        XCD_IDX_PER:  next_periph_ctl = wbyte;
        XCD_IDX_ROM:  next_rom_attr   = wbyte;
        XCD_IDX_MCTL: next_mem_ctl    = wbyte;
        default:      next_rom_attr   = rom_attr; // unmapped: ignored
      endcase
    end
    if (read_i & ~ack_q) begin
      // captured in the wait cycle, stands when waitrequest drops
      next_rdata = '0;
      unique case (reg_idx)
        XCD_IDX_PER:  next_rdata[7:0] = periph_ctl;
        XCD_IDX_ROM:  next_rdata[7:0] = rom_attr;
        XCD_IDX_MCTL: next_rdata[7:0] = mem_ctl;
        XCD_IDX_STAT: next_rdata[3:0] = {~memsel_n, enc};
        default:      next_rdata      = '0; // unmapped reads zero
      endcase
    end
  end

  // register file flops, reset loads the documented defaults
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      periph_ctl <= XCD_RST_PER;
      rom_attr   <= XCD_RST_ROM;
      mem_ctl    <= XCD_RST_MCTL;
      ack_q      <= 1'b0;
      rdata      <= '0;
    end else begin
      periph_ctl <= next_periph_ctl;
      rom_attr   <= next_rom_attr;
      mem_ctl    <= next_mem_ctl;
      ack_q      <= next_ack_q;
      rdata      <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // cycle decode; priority keeps only one select per cycle
  always_comb begin
    next_enc      = XCD_E_IDLE;  // idle is all ones
    next_memsel_n = 1'b1;
    if (cyc_valid_i && cyc_io_i) begin
      if (periph_ctl[XCD_B_CFG] && cyc_write_i &&
          io_a == XCD_A_CPAGE) begin
        next_enc = XCD_E_CPAGE;
      end else if (periph_ctl[XCD_B_CFG] &&
                   io_a[15:8] == XCD_A_CMEM) begin
        next_enc = XCD_E_CMEM;
      end else if (periph_ctl[XCD_B_P92] && io_a == XCD_A_P92) begin
        next_enc = XCD_E_P92;
      end else if (com_hit(sel_a, io_a)) begin
        next_enc = XCD_E_COMA;
      end else if (com_hit(sel_b, io_a)) begin
        // a shared range already went to port a above
        next_enc = XCD_E_COMB;
      end else if ((sel_lpt == XCD_LPT1 && io_a[15:2] == XCD_A_LPT1) ||
                   (sel_lpt == XCD_LPT2 && io_a[15:3] == XCD_A_LPT2) ||
                   (sel_lpt == XCD_LPT3 && io_a[15:3] == XCD_A_LPT3)) begin
        next_enc = XCD_E_LPT;
      end
    end else if (cyc_valid_i && mem_ctl[XCD_B_MEN] &&
                 cyc_addr_i[23:16] == XCD_A_ROM &&
                 cyc_addr_i[15:14] == seg &&
                 cyc_addr_i[17:16] == XCD_A_ROMQ[1:0]) begin
      // read and write permission are separate per segment
      if (cyc_write_i) begin
        next_memsel_n = ~seg_wr[seg];
      end else begin
        next_memsel_n = ~seg_rd[seg];
      end
    end
    // transceiver only opens for a decoded peripheral
    next_xcvr_n = (next_enc == XCD_E_IDLE);
  end

  // outputs come straight from these flops, one cycle after the request
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc      <= XCD_E_IDLE;
      xcvr_n   <= 1'b1;
      memsel_n <= 1'b1;
    end else begin
      enc      <= next_enc;
      xcvr_n   <= next_xcvr_n;
      memsel_n <= next_memsel_n;
    end
  end

  assign encoded_select_lines_o      = enc;
  assign xbus_transceiver_enable_n_o = xcvr_n;
  assign system_memory_select_n_o    = memsel_n;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  logic io_v;     // valid i/o cycle
  logic mem_v;    // valid memory cycle in the rom window
  logic seen_q;   // first edge after reset passed
  assign io_v  = cyc_valid_i & cyc_io_i;
  assign mem_v = cyc_valid_i & ~cyc_io_i & (cyc_addr_i[23:16] == XCD_A_ROM);

  // helper for the reset check only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  a_cfg_page_sel: assert property (
    io_v && cyc_write_i && io_a == XCD_A_CPAGE && periph_ctl[XCD_B_CFG]
    |=> enc == XCD_E_CPAGE && !xcvr_n)
    else $error("config page select missing");

  a_cfg_mem_sel: assert property (
    io_v && io_a[15:8] == XCD_A_CMEM && periph_ctl[XCD_B_CFG]
    |=> enc == XCD_E_CMEM)
    else $error("config memory select missing");

  a_cfg_off: assert property (
    !periph_ctl[XCD_B_CFG]
    |=> enc != XCD_E_CPAGE && enc != XCD_E_CMEM)
    else $error("config select while disabled");

  a_port92_gate: assert property (
    io_v && io_a == XCD_A_P92
    |=> (enc == XCD_E_P92) == $past(periph_ctl[XCD_B_P92]))
    else $error("port 92 decode wrong");

  a_lpt_range: assert property (
    io_v && sel_lpt == XCD_LPT2 && io_a[15:3] == XCD_A_LPT2
    |=> enc == XCD_E_LPT ##1 1'b1)
    else $error("parallel range not decoded");

  a_reset_fields: assert property (
    !seen_q |-> periph_ctl == XCD_RST_PER && rom_attr == XCD_RST_ROM)
    else $error("decode fields not at reset value");

  a_serial_b_off: assert property (
    sel_b[1] |=> enc != XCD_E_COMB)
    else $error("serial b selected while off");

  a_serial_dup: assert property (
    io_v && sel_a == sel_b && com_hit(sel_a, io_a)
    |=> enc == XCD_E_COMA)
    else $error("shared serial range not port a");

  a_xcvr_pair: assert property (
    xcvr_n == (enc == XCD_E_IDLE))
    else $error("transceiver and select disagree");

  // a switched-off parallel port must stay silent on its old range
  a_port_off: assert property (
    io_v && (&sel_lpt) && io_a[15:3] == XCD_A_LPT2
    |=> enc == XCD_E_IDLE && xcvr_n)
    else $error("disabled parallel port decoded");

  a_rom_read: assert property (
    mem_v && !cyc_write_i && mem_ctl[XCD_B_MEN] && seg_rd[seg]
    |=> !memsel_n)
    else $error("rom read not selected");

  a_rom_write: assert property (
    mem_v && cyc_write_i && mem_ctl[XCD_B_MEN] && seg_wr[seg]
    |=> !memsel_n)
    else $error("rom write not selected");

  a_rom_block: assert property (
    !mem_ctl[XCD_B_MEN] || (mem_v && rom_attr[2*seg +: 2] == 2'h0)
    |=> memsel_n)
    else $error("memory select while blocked");

  a_idle_high: assert property (
    !cyc_valid_i |=> enc == XCD_E_IDLE && memsel_n && xcvr_n)
    else $error("select asserted without a cycle");

  c_cfg_page: cover property (io_v ##1 enc == XCD_E_CPAGE);
  c_serial_b: cover property (io_v ##1 enc == XCD_E_COMB);
  c_rom_write: cover property (mem_v && cyc_write_i ##1 !memsel_n);
  c_reg_write: cover property (write_i && !waitrequest_o);
  c_port92:    cover property (io_v ##1 enc == XCD_E_P92);

endmodule

// file: test/xcd_xbus_model.sv
`timescale 1ns/100ps
// far side: utility bus peripherals and system memory, watching selects
module xcd_xbus_model (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [2:0]  sel_i,     // encoded select, 7 idle
  input  wire logic        xcvr_n_i,  // transceiver enable, active low
  input  wire logic        mem_n_i,   // memory select, active low
  output logic             fault_o,   // sticky, seen an illegal mix
  output logic [15:0]      hits_o     // selects answered
);
  ////////////////////////////////////////////////////////////////////////
  // a peripheral selected with its transceiver shut would float the byte
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_o <= 1'b0;
      hits_o  <= 16'h0000;
    end else begin
      if ((sel_i != 3'h7) == xcvr_n_i) fault_o <= 1'b1;
      // memory and i/o selects never together
      if (!mem_n_i && sel_i != 3'h7) fault_o <= 1'b1;
      if (sel_i != 3'h7 || !mem_n_i) hits_o <= hits_o + 16'h0001;
    end
  end
endmodule

// file: test/test_xbus_chip_select_decode.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module test_xbus_chip_select_decode;
  import xcd_pkg::*;
  logic              clock_i      = 1'b0;
  logic              nrst_i       = 1'b0;
  logic [XCD_AW-1:0] address_i    = '0;
  logic              read_i       = 1'b0;
  logic              write_i      = 1'b0;
  logic [XCD_DW-1:0] writedata_i  = '0;
  logic [3:0]        byteenable_i = 4'h0;
  logic              cyc_valid_i  = 1'b0;
  logic              cyc_io_i     = 1'b0;
  logic              cyc_write_i  = 1'b0;
  logic [23:0]       cyc_addr_i   = 24'h000000;
  logic [XCD_DW-1:0] readdata_o;
  logic              waitrequest_o;
  logic [2:0]        enc;
  logic              xcvr_n;
  logic              mem_n;
  logic              fault;
  logic [15:0]       hits;                     // selects the far side saw
  logic [15:0]       hits_m       = 16'h0000;  // selects expected there
  int                err_total    = 0;
  int                compares     = 0;
  logic [31:0]       seed         = 32'h90e4;  // lfsr state
  logic [7:0]        per_m, rom_m, mctl_m;     // bench register copies
  logic              wr_s;                     // waitrequest before edge
  logic [31:0]       rd_s;                     // readdata before edge
  logic [7:0]        d;
  logic [15:0]       a;
  localparam logic [15:0] BASES [8] = '{16'h0c00, 16'h0800, 16'h0092,
    16'h03f8, 16'h02f8, 16'h03bc, 16'h0378, 16'h0278};

  xcd_decode dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
    .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .cyc_valid_i(cyc_valid_i), .cyc_io_i(cyc_io_i),
    .cyc_write_i(cyc_write_i), .cyc_addr_i(cyc_addr_i),
    .encoded_select_lines_o(enc), .xbus_transceiver_enable_n_o(xcvr_n),
    .system_memory_select_n_o(mem_n));
  xcd_xbus_model far_u (.clock_i(clock_i), .nrst_i(nrst_i), .sel_i(enc),
    .xcvr_n_i(xcvr_n), .mem_n_i(mem_n), .fault_o(fault), .hits_o(hits));

  ////////////////////////////////////////////////////////////////////////
  always #2 clock_i = ~clock_i;
  // inputs only move at rising edges, so mid-cycle values are settled
  always @(negedge clock_i) begin
    wr_s = waitrequest_o;
    rd_s = readdata_o;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // serial field hit: 00 first range, 01 second, others nothing
  function automatic logic ser(input logic [1:0] c, input logic [15:0] b);
    return (c == 2'h0 && b[15:3] == 13'h007f) ||
           (c == 2'h1 && b[15:3] == 13'h005f);
  endfunction
  function automatic logic [2:0] exp_enc(input logic w, input logic [15:0] b);
    logic [1:0] lp;
    lp = per_m[5:4];
    if (per_m[7] && w && b == 16'h0c00) return 3'h0;
    if (per_m[7] && b[15:8] == 8'h08) return 3'h1;
    if (per_m[6] && b == 16'h0092) return 3'h2;
    if (ser(per_m[1:0], b)) return 3'h3;
    if (ser(per_m[3:2], b) && per_m[3:2] != per_m[1:0])
      return 3'h4;
    if ((lp == 2'h0 && b[15:2] == 14'h00ef) ||
        (lp == 2'h1 && b[15:3] == 13'h006f) ||
        (lp == 2'h2 && b[15:3] == 13'h004f)) return 3'h5;
    return 3'h7;
  endfunction

  task wrap_up;
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
           input logic be, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clock_i);
    address_i    <= {idx, 2'b00};
    read_i       <= !w;
    write_i      <= w;
    writedata_i  <= {24'h000000, wd};
    byteenable_i <= {3'b000, be};
    do begin
      @(posedge clock_i);
      n++;
    end while (wr_s !== 1'b0 && n < 20);
    if (wr_s !== 1'b0) begin
      err_total++;
      wrap_up();
    end
    rd = rd_s[7:0];
    if (!w) `CHK("rd_upper", 24'h000000, rd_s[31:8])
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask
  task wreg(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v, 1'b1, d);
    if (idx == 8'h4f) per_m = v;
    if (idx == 8'h54) rom_m = v;
    if (idx == 8'h20) mctl_m = v;
  endtask
  // one decoded bus cycle, checked one edge after it is sampled
  task cyc(input logic io, input logic w, input logic [23:0] ad);
    logic [2:0] e;
    logic       m;
    e = io ? exp_enc(w, ad[15:0]) : 3'h7;
    m = !(!io && mctl_m[4] && ad[23:16] == 8'h0c && rom_m[{ad[15:14], w}]);
    @(posedge clock_i);
    cyc_valid_i <= 1'b1;
    cyc_io_i    <= io;
    cyc_write_i <= w;
    cyc_addr_i  <= ad;
    @(posedge clock_i);
    cyc_valid_i <= 1'b0;
    @(negedge clock_i);
    `CHK("encoded", e, enc)
    `CHK("xcvr_n", e == 3'h7, xcvr_n)
    `CHK("mem_n", m, mem_n)
    if (e != 3'h7 || !m) hits_m = hits_m + 16'h0001;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    per_m = 8'h4f;
    rom_m = 8'h00;
    mctl_m = 8'h00;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    bus(1'b0, 8'h4f, 8'h00, 1'b1, d);
    `CHK("per_rst", 8'h4f, d)
    bus(1'b0, 8'h54, 8'h00, 1'b1, d);
    `CHK("rom_rst", 8'h00, d)
    bus(1'b0, 8'h10, 8'h00, 1'b1, d);
    `CHK("unmapped", 8'h00, d)
    cyc(1'b1, 1'b0, 24'h0003bd);
    cyc(1'b1, 1'b0, 24'h0003f8);
    cyc(1'b1, 1'b1, 24'h0002ff);
    wreg(8'h4f, 8'hc0);
    cyc(1'b1, 1'b1, 24'h0003fc);
    cyc(1'b1, 1'b1, 24'h000c00);
    cyc(1'b1, 1'b0, 24'h000c00);
    cyc(1'b1, 1'b0, 24'h0008ff);
    bus(1'b1, 8'h4f, 8'h3f, 1'b0, d);
    bus(1'b0, 8'h4f, 8'h00, 1'b1, d);
    `CHK("be_off", 8'hc0, d)
    for (int i = 0; i < 400; i++) begin
      if (i % 8 == 0) begin
        seed = lfsr(seed);
        wreg(8'h4f, seed[7:0]);
        wreg(8'h54, seed[15:8]);
        wreg(8'h20, {3'b000, seed[16], 4'h0});
        bus(1'b0, 8'h54, 8'h00, 1'b1, d);
        `CHK("rom_rw", rom_m, d)
      end
      seed = lfsr(seed);
      a = BASES[seed[2:0]] | (seed[3] ? {13'h0000, seed[6:4]} : 16'h0000);
      if (seed[13]) cyc(1'b1, seed[7], {8'h00, a});
      else cyc(1'b0, seed[7], {seed[14] ? 8'h0c : 8'h0d, seed[31:16]});
    end
    @(negedge clock_i);                    // far side counts the last one
    `CHK("far_side", 1'b0, fault)
    `CHK("hits", hits_m, hits)
    // second reset in mid-run must reload the defaults
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    bus(1'b0, 8'h4f, 8'h00, 1'b1, d);
    `CHK("per_rst2", 8'h4f, d)
    bus(1'b0, 8'h20, 8'h00, 1'b1, d);
    `CHK("mctl_rst2", 8'h00, d)
    wrap_up();
  end
endmodule
